// ### logic/lpcc_defs.vh
// Register offsets, field positions, reset values and timing counts of the
// low-power clock control block.
// Assumes 32-bit APB data with one register to an aligned word.
`ifndef LPCC_DEFS_VH
`define LPCC_DEFS_VH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define LPCC_ADDR_W           8
`define LPCC_OFF_LPMC         8'h00
`define LPCC_OFF_CKSC         8'h04
`define LPCC_OFF_STAT         8'h08
`define LPCC_OFF_WAKE         8'h0C

// ----------------------------------------------------------------------------
// Low power mode control fields
// ----------------------------------------------------------------------------
`define LPCC_LPMC_STOP        7
`define LPCC_LPMC_SLEEP       6
`define LPCC_LPMC_TIMER       5
`define LPCC_LPMC_CG_HI       2
`define LPCC_LPMC_CG_LO       1
`define LPCC_LPMC_RST_VAL     8'h18
`define LPCC_LPMC_RW_MASK     8'h26

// ----------------------------------------------------------------------------
// Clock select control fields
// ----------------------------------------------------------------------------
`define LPCC_CKSC_ACTIVE      6
`define LPCC_CKSC_WS_HI       5
`define LPCC_CKSC_WS_LO       4
`define LPCC_CKSC_MCS         2
`define LPCC_CKSC_CS_HI       1
`define LPCC_CKSC_CS_LO       0
`define LPCC_CKSC_RST_VAL     8'hFC
`define LPCC_CKSC_FIXED       8'h88

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define LPCC_CLK_MHZ          40
`define LPCC_PLL_LOCK_US      100
`define LPCC_PLL_LOCK_CYC     (`LPCC_PLL_LOCK_US * `LPCC_CLK_MHZ)
`define LPCC_OSC_WAIT0_CYC    16
`define LPCC_OSC_WAIT1_CYC    256
`define LPCC_OSC_WAIT2_CYC    1024
`define LPCC_OSC_WAIT3_CYC    4096

// ----------------------------------------------------------------------------
// Operating modes
// ----------------------------------------------------------------------------
`define LPCC_MODE_PLL_RUN     3'h0
`define LPCC_MODE_PLL_SLEEP   3'h1
`define LPCC_MODE_TIMER       3'h2
`define LPCC_MODE_MAIN_RUN    3'h3
`define LPCC_MODE_MAIN_SLEEP  3'h4
`define LPCC_MODE_STOP        3'h5
`define LPCC_MODE_HW_STANDBY  3'h6

`endif

// ### logic/lpcc_intermit.v
// Intermittent CPU clock enable generator.
// Assumes access_i marks cycles in which the CPU performs a bus or memory access.
`timescale 1ns/1ps
`default_nettype none

module lpcc_intermit
#(
   parameter CNT_W = 2
)
(
   // Clock and reset
   input  wire             clk_sys_i,
   input  wire             rst_n_i,
   input  wire             clk_en_i,
   // Control
   input  wire [CNT_W-1:0] ratio_i,
   input  wire             access_i,
   // Output
   output wire             cpu_tick_o
);

   reg [CNT_W-1:0] cnt_q;
   reg [CNT_W-1:0] cnt_d;

   // ----------------------------------------------------------------------------
   // Stretch counter
   // ----------------------------------------------------------------------------
   always @*
   begin
      cnt_d = cnt_q;
      if (access_i && (ratio_i != {CNT_W{1'b0}}))
      begin
         if (cnt_q == ratio_i)
            cnt_d = {CNT_W{1'b0}};
         else
            cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      else
         cnt_d = {CNT_W{1'b0}};
   end

   always @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
         cnt_q <= {CNT_W{1'b0}};
      else if (clk_en_i)
         cnt_q <= cnt_d;
   end

   assign cpu_tick_o = !access_i || (ratio_i == {CNT_W{1'b0}}) || (cnt_q == ratio_i);

endmodule

`default_nettype wire

// ### logic/lpcc_top.v
// Low-power and clock-selection controller with an APB register slave.
// Assumes synchronous inputs on clk_sys_i; the oscillator, PLL and gating
// cells outside act on the enables and selects driven here.
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "lpcc_defs.vh"

// Behaviour
// - Main clock and main sleep modes stop the PLL, except while its lock delay runs, and run oscillator over two.
// - Both sleep modes halt only the CPU clock; peripherals keep running.
// - Timer mode stops everything except the timebase timer; the code keeps the PLL running when timer mode is entered from PLL mode.
// - Stop and hardware standby halt the oscillator; stored state is kept.
// - Every mode except PLL clock mode is flagged as low power.
// - Intermittent mode stretches CPU clock during accesses; peripherals run full speed.
// - Two-bit multiplier field selects PLL ratio one to four.
// - Two-bit wait field sets oscillator settle time on leaving stop or standby.
// - Clearing main select enters PLL mode after lock delay, with selected ratio.
// - Setting main select returns to main clock; standby or watchdog reset sets it.
// - PLL to main switch happens at a synchronized clock point, except when a stop write or hardware standby leaves PLL mode at once.
// - The timebase timer always runs from the main oscillator clock.
module lpcc_top
#(
   parameter PLL_LOCK_CYC = `LPCC_PLL_LOCK_CYC,
   parameter OSC_WAIT3    = `LPCC_OSC_WAIT3_CYC
)
(
   // Clock, reset and enable
   input  wire        clk_sys_i,
   input  wire        rst_n_i,
   input  wire        clk_en_i,
   // APB slave
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [7:0]  paddr_i,
   input  wire [31:0] pwdata_i,
   output wire [31:0] prdata_o,
   output wire        pready_o,
   output wire        pslverr_o,
   // System events
   input  wire        hw_standby_i,
   input  wire        watchdog_rst_i,
   input  wire        wake_i,
   input  wire        clk_sync_i,
   input  wire        cpu_access_i,
   // Clock controls
   output wire        osc_en_o,
   output wire        pll_en_o,
   output wire [1:0]  pll_mult_o,
   output wire        sel_pll_o,
   output wire        cpu_clk_en_o,
   output wire        periph_clk_en_o,
   output wire        timebase_clk_en_o,
   output wire        low_power_o,
   output wire [2:0]  mode_o
);

   localparam ST_MAIN     = 3'h0;
   localparam ST_PLL_WAIT = 3'h1;
   localparam ST_PLL      = 3'h2;
   localparam ST_SYNC     = 3'h3;
   localparam ST_STOP     = 3'h4;
   localparam ST_OSC_WAIT = 3'h5;

   reg  [7:0]  lpmc_q;
   reg  [7:0]  cksc_q;
   reg  [2:0]  st_q;
   reg  [2:0]  st_d;
   reg         sleep_q;
   reg         timer_q;
   reg         standby_q;
   reg  [31:0] cnt_q;
   reg  [31:0] cnt_d;
   reg  [31:0] wait_cyc;
   reg  [31:0] rdata_q;
   reg  [31:0] rdata_d;
   reg  [2:0]  mode_q;
   reg  [2:0]  mode_d;
   wire        wr_en;
   wire        rd_en;
   wire        main_clock_select;
   wire        stop_wr;
   wire        sleep_wr;
   wire        addr_ok;
   wire        cpu_tick;

   // ----------------------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------------------
   assign wr_en     = psel_i && penable_i && pwrite_i && clk_en_i;
   assign rd_en     = psel_i && !penable_i && !pwrite_i && clk_en_i;
   assign addr_ok   = (paddr_i == `LPCC_OFF_LPMC) || (paddr_i == `LPCC_OFF_CKSC) ||
                      (paddr_i == `LPCC_OFF_STAT) || (paddr_i == `LPCC_OFF_WAKE);
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i && penable_i && !addr_ok;
   assign prdata_o  = rdata_q;
   assign stop_wr   = wr_en && (paddr_i == `LPCC_OFF_LPMC) && pwdata_i[`LPCC_LPMC_STOP];
   assign sleep_wr  = wr_en && (paddr_i == `LPCC_OFF_LPMC) && pwdata_i[`LPCC_LPMC_SLEEP];
   assign main_clock_select       = cksc_q[`LPCC_CKSC_MCS];

   // ----------------------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------------------
   always @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         lpmc_q <= `LPCC_LPMC_RST_VAL;
         cksc_q <= `LPCC_CKSC_RST_VAL;
      end
      else if (clk_en_i)
      begin
         if (wr_en && (paddr_i == `LPCC_OFF_CKSC))
         begin
            cksc_q[`LPCC_CKSC_WS_HI:`LPCC_CKSC_WS_LO] <= pwdata_i[5:4];
            cksc_q[`LPCC_CKSC_MCS]                     <= pwdata_i[2];
            cksc_q[`LPCC_CKSC_CS_HI:`LPCC_CKSC_CS_LO] <= pwdata_i[1:0];
         end
         if (hw_standby_i || watchdog_rst_i)
            cksc_q[`LPCC_CKSC_MCS] <= 1'b1;
         if (wr_en && (paddr_i == `LPCC_OFF_LPMC))
            lpmc_q <= (lpmc_q & ~`LPCC_LPMC_RW_MASK) | (pwdata_i[7:0] & `LPCC_LPMC_RW_MASK);
      end
   end

   // ----------------------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------------------
   always @*
   begin
      rdata_d = rdata_q;
      if (rd_en)
      begin
         case (paddr_i)
            `LPCC_OFF_LPMC : rdata_d = {24'h000000, 2'b00, lpmc_q[5:0]};
            `LPCC_OFF_CKSC : rdata_d = {24'h000000, (cksc_q & ~8'h40) | `LPCC_CKSC_FIXED |
                                       {1'b0, (st_q == ST_MAIN || st_q == ST_PLL_WAIT), 6'h00}};
            `LPCC_OFF_STAT : rdata_d = {26'h0000000, low_power_o, st_q, mode_q[1:0]};
            `LPCC_OFF_WAKE : rdata_d = cnt_q;
            default        : rdata_d = 32'h00000000;
         endcase
      end
   end

   always @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
         rdata_q <= 32'h00000000;
      else if (clk_en_i)
         rdata_q <= rdata_d;
   end

   // ----------------------------------------------------------------------------
   // Oscillator wait selection
   // ----------------------------------------------------------------------------
   always @*
   begin
      case (cksc_q[`LPCC_CKSC_WS_HI:`LPCC_CKSC_WS_LO])
         2'b00   : wait_cyc = `LPCC_OSC_WAIT0_CYC;
         2'b01   : wait_cyc = `LPCC_OSC_WAIT1_CYC;
         2'b10   : wait_cyc = `LPCC_OSC_WAIT2_CYC;
         default : wait_cyc = OSC_WAIT3;
      endcase
   end

   // ----------------------------------------------------------------------------
   // Clock source sequencer
   // ----------------------------------------------------------------------------
   always @*
   begin
      st_d  = st_q;
      cnt_d = cnt_q;
      case (st_q)
         ST_MAIN :
         begin
            if (!main_clock_select)
            begin
               st_d  = ST_PLL_WAIT;
               cnt_d = PLL_LOCK_CYC;
            end
         end
         ST_PLL_WAIT :
         begin
            if (main_clock_select)
               st_d = ST_MAIN;
            else if (cnt_q <= 32'h00000001)
            begin
               st_d  = ST_PLL;
               cnt_d = 32'h00000000;
            end
            else
               cnt_d = cnt_q - 32'h00000001;
         end
         ST_PLL :
         begin
            if (main_clock_select)
               st_d = ST_SYNC;
         end
         ST_SYNC :
         begin
            if (clk_sync_i)
               st_d = ST_MAIN;
         end
         ST_STOP :
         begin
            if (wake_i && !standby_q)
            begin
               st_d  = ST_OSC_WAIT;
               cnt_d = wait_cyc;
            end
         end
         ST_OSC_WAIT :
         begin
            if (cnt_q <= 32'h00000001)
            begin
               st_d  = ST_MAIN;
               cnt_d = 32'h00000000;
            end
            else
               cnt_d = cnt_q - 32'h00000001;
         end
         default :
            st_d = ST_MAIN;
      endcase
      if (stop_wr || (hw_standby_i && st_q != ST_STOP))
      begin
         st_d  = ST_STOP;
         cnt_d = 32'h00000000;
      end
   end

   always @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         st_q      <= ST_MAIN;
         cnt_q     <= 32'h00000000;
         sleep_q   <= 1'b0;
         timer_q   <= 1'b0;
         standby_q <= 1'b0;
         mode_q    <= `LPCC_MODE_MAIN_RUN;
      end
      else if (clk_en_i)
      begin
         st_q      <= st_d;
         cnt_q     <= cnt_d;
         standby_q <= hw_standby_i;
         mode_q    <= mode_d;
         if (stop_wr)
         begin
            sleep_q <= 1'b0;
            timer_q <= 1'b0;
         end
         else if (sleep_wr)
         begin
            sleep_q <= 1'b1;
            timer_q <= pwdata_i[`LPCC_LPMC_TIMER];
         end
         else if (wake_i)
         begin
            sleep_q <= 1'b0;
            timer_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Mode classification
   // ----------------------------------------------------------------------------
   always @*
   begin
      if (st_q == ST_STOP || st_q == ST_OSC_WAIT)
         mode_d = standby_q ? `LPCC_MODE_HW_STANDBY : `LPCC_MODE_STOP;
      else if (timer_q)
         mode_d = `LPCC_MODE_TIMER;
      else if ((st_q == ST_PLL) || (st_q == ST_SYNC))
         mode_d = sleep_q ? `LPCC_MODE_PLL_SLEEP : `LPCC_MODE_PLL_RUN;
      else
         mode_d = sleep_q ? `LPCC_MODE_MAIN_SLEEP : `LPCC_MODE_MAIN_RUN;
   end

   // ----------------------------------------------------------------------------
   // Intermittent CPU clock
   // ----------------------------------------------------------------------------
   lpcc_intermit
   #(
      .CNT_W (2)
   )
   u_intermit
   (
      .clk_sys_i  (clk_sys_i),
      .rst_n_i    (rst_n_i),
      .clk_en_i   (clk_en_i),
      .ratio_i    (lpmc_q[`LPCC_LPMC_CG_HI:`LPCC_LPMC_CG_LO]),
      .access_i   (cpu_access_i),
      .cpu_tick_o (cpu_tick)
   );

   // ----------------------------------------------------------------------------
   // Clock enables
   // ----------------------------------------------------------------------------
   assign osc_en_o          = ((mode_q != `LPCC_MODE_STOP) &&
                               (mode_q != `LPCC_MODE_HW_STANDBY)) ||
                              (st_q == ST_OSC_WAIT);
   assign pll_en_o          = (st_q == ST_PLL_WAIT) || (st_q == ST_PLL) ||
                              (st_q == ST_SYNC);
   assign sel_pll_o         = (st_q == ST_PLL) || (st_q == ST_SYNC);
   assign pll_mult_o        = cksc_q[`LPCC_CKSC_CS_HI:`LPCC_CKSC_CS_LO];

   // ----------------------------------------------------------------------------
   // Clock gating
   // ----------------------------------------------------------------------------
   assign cpu_clk_en_o      = osc_en_o && !sleep_q && !timer_q &&
                              (st_q != ST_OSC_WAIT) && cpu_tick;
   assign periph_clk_en_o   = osc_en_o && !timer_q && (st_q != ST_OSC_WAIT);
   assign timebase_clk_en_o = osc_en_o;
   assign low_power_o       = (mode_q != `LPCC_MODE_PLL_RUN);
   assign mode_o            = mode_q;

endmodule

`default_nettype wire

// ### dv/lpcc_assertions.sv
// Checker of the clock control block outputs.
// Assumes binding to lpcc_top; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
`include "lpcc_defs.vh"
module lpcc_assertions
#(
   parameter PLL_LOCK_CYC = 10
)
(
   // Clock and reset
   input wire logic        clk_sys_i,
   input wire logic        rst_n_i,
   input wire logic        clk_en_i,
   // Bus and events
   input wire logic        wake_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [7:0]  paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic        hw_standby_i,
   input wire logic        clk_sync_i,
   // Clock controls
   input wire logic        osc_en_o,
   input wire logic        pll_en_o,
   input wire logic [1:0]  pll_mult_o,
   input wire logic        sel_pll_o,
   input wire logic        cpu_clk_en_o,
   input wire logic        periph_clk_en_o,
   input wire logic        timebase_clk_en_o,
   input wire logic        low_power_o,
   input wire logic [2:0]  mode_o
);
   // ------------------------------------------------------------
   // Lock counter and properties
   // ------------------------------------------------------------
   logic [15:0] lock_q;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i || !pll_en_o)
         lock_q <= 16'h0000;
      else
         lock_q <= lock_q + 16'h0001;
   end
   low_pw_a: assert property ((low_power_o == (mode_o != `LPCC_MODE_PLL_RUN)) &&
      (low_power_o || $past(sel_pll_o)))
      else $error("low power flag wrong");
   main_osc_a: assert property (mode_o == `LPCC_MODE_MAIN_RUN |-> !$past(sel_pll_o))
      else $error("PLL selected in main mode");
   pll_run_a: assert property (mode_o == `LPCC_MODE_PLL_RUN |-> $past(sel_pll_o) && timebase_clk_en_o)
      else $error("PLL mode without PLL source");
   sleep_cpu_a: assert property ((mode_o == `LPCC_MODE_MAIN_SLEEP) ||
      (mode_o == `LPCC_MODE_PLL_SLEEP)
      |-> $past(!cpu_clk_en_o && periph_clk_en_o && timebase_clk_en_o))
      else $error("sleep gating wrong");
   timer_only_a: assert property (mode_o == `LPCC_MODE_TIMER
      |-> $past(!cpu_clk_en_o && !periph_clk_en_o && timebase_clk_en_o))
      else $error("timer gating wrong");
   stop_osc_a: assert property ($rose(mode_o == `LPCC_MODE_STOP) && !$past(wake_i) |-> !osc_en_o)
      else $error("oscillator runs in stop");
   sync_sw_a: assert property ($fell(sel_pll_o) && !$past(hw_standby_i) |-> $past(clk_sync_i))
      else $error("unsynchronized switch back");
   lock_wait_a: assert property ($rose(sel_pll_o) |-> lock_q >= PLL_LOCK_CYC - 1)
      else $error("PLL chosen before lock");
   mult_set_a: assert property (clk_en_i && psel_i && penable_i && pwrite_i
      && paddr_i == `LPCC_OFF_CKSC |=> pll_mult_o == $past(pwdata_i[1:0]))
      else $error("multiplier not taken");
   cover property (mode_o == `LPCC_MODE_PLL_SLEEP);
   cover property ($rose(sel_pll_o));
   cover property (mode_o == `LPCC_MODE_TIMER);
   cover property (mode_o == `LPCC_MODE_STOP);
endmodule
`default_nettype wire

// ### dv/tb_low_power_clock_control.sv
// Testbench of the clock control block.
// Assumes lpcc_top with short lock and wait counts.
`timescale 1ns/1ps
`default_nettype none
`include "lpcc_defs.vh"
module tb_low_power_clock_control;
   localparam   LOCK = 10;
   logic        clk_sys_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        clk_en_i = 1'b1;
   logic        psel_i = 1'b0;
   logic        penable_i = 1'b0;
   logic        pwrite_i = 1'b0;
   logic [7:0]  paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0;
   logic        hw_standby_i = 1'b0;
   logic        watchdog_rst_i = 1'b0;
   logic        wake_i = 1'b0;
   logic        clk_sync_i = 1'b0;
   logic        cpu_access_i = 1'b0;
   wire  [31:0] prdata_o;
   wire  [1:0]  pll_mult_o;
   wire  [2:0]  mode_o;
   wire         pready_o, pslverr_o, osc_en_o, pll_en_o, sel_pll_o;
   wire         cpu_clk_en_o, periph_clk_en_o, timebase_clk_en_o, low_power_o;
   int          error_cnt = 0;
   int          n_compared = 0;
   int          cyc = 0;
   int          n, k;
   logic [32:0] expq[$];
   int          wt[4] = '{16, 256, 1024, 8};
   // ------------------------------------------------------------
   // Design, clock and helpers
   // ------------------------------------------------------------
   lpcc_top #(.PLL_LOCK_CYC(LOCK), .OSC_WAIT3(8)) uut
   (
      .clk_sys_i, .rst_n_i, .clk_en_i, .psel_i, .penable_i, .pwrite_i,
      .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .hw_standby_i,
      .watchdog_rst_i, .wake_i, .clk_sync_i, .cpu_access_i, .osc_en_o,
      .pll_en_o, .pll_mult_o, .sel_pll_o, .cpu_clk_en_o, .periph_clk_en_o,
      .timebase_clk_en_o, .low_power_o, .mode_o
   );
   initial
   begin
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end
   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_sys_i);
      penable_i <= 1'b1;
      @(posedge clk_sys_i);
      while (pready_o !== 1'b1)
         @(posedge clk_sys_i);
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      expq.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic wm(input logic [2:0] m);
      for (int i = 0; i < 80 && mode_o !== m; i++)
         @(posedge clk_sys_i);
      chk(mode_o, m);
   endtask
   task automatic wpl();
      for (n = 0; sel_pll_o !== 1'b1 && n < 60; n++)
         @(posedge clk_sys_i);
      @(posedge clk_sys_i);
   endtask
   task automatic wk();
      wake_i <= 1'b1;
      @(posedge clk_sys_i);
      wake_i <= 1'b0;
      for (n = 0; mode_o !== `LPCC_MODE_MAIN_RUN && n < 2000; n++)
         @(posedge clk_sys_i);
   endtask
   always @(posedge clk_sys_i)
   begin
      cyc++;
      if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1)
         chk({pslverr_o, prdata_o}, expq.pop_front());
      if (cyc == 30000)
      begin
         error_cnt++;
         test_done();
      end
   end
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial
   begin
      void'($urandom(32'hC23B));
      repeat (12) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      @(posedge clk_sys_i);
      chk({osc_en_o, sel_pll_o, low_power_o, mode_o}, {3'b101, 3'h3});
      rd(`LPCC_OFF_LPMC, 33'h18);
      rd(`LPCC_OFF_CKSC, 33'hFC);
      rd(8'h10, 33'h1_0000_0000);
      $display("test reset done");
      for (int m = 0; m < 4; m++)
      begin
         apb(1'b1, `LPCC_OFF_CKSC, 32'h30 | m);
         wpl();
         chk(n >= LOCK - 2 && n <= LOCK + 2, 1'b1);
         chk({pll_mult_o, low_power_o, mode_o}, {m[1:0], 1'b0, 3'h0});
         rd(`LPCC_OFF_CKSC, 33'hB8 | m);
         if (m == 1)
         begin
            apb(1'b1, `LPCC_OFF_LPMC, 32'h40);
            wm(`LPCC_MODE_PLL_SLEEP);
            chk({cpu_clk_en_o, periph_clk_en_o, sel_pll_o}, 3'b011);
            wake_i <= 1'b1;
            @(posedge clk_sys_i);
            wake_i <= 1'b0;
            wm(`LPCC_MODE_PLL_RUN);
         end
         k = $urandom_range(9, 2);
         apb(1'b1, `LPCC_OFF_CKSC, ($urandom << 8) | 32'h34 | m);
         repeat (k) @(posedge clk_sys_i);
         chk(sel_pll_o, 1'b1);
         clk_sync_i <= 1'b1;
         wm(`LPCC_MODE_MAIN_RUN);
         clk_sync_i <= 1'b0;
      end
      $display("test pll done");
      apb(1'b1, `LPCC_OFF_LPMC, 32'h40);
      wm(`LPCC_MODE_MAIN_SLEEP);
      chk({cpu_clk_en_o, periph_clk_en_o, timebase_clk_en_o}, 3'b011);
      rd(`LPCC_OFF_LPMC, 33'h18);
      wk();
      apb(1'b1, `LPCC_OFF_LPMC, 32'h60);
      wm(`LPCC_MODE_TIMER);
      chk({cpu_clk_en_o, periph_clk_en_o, timebase_clk_en_o}, 3'b001);
      wk();
      apb(1'b1, `LPCC_OFF_LPMC, 32'h26);
      rd(`LPCC_OFF_LPMC, 33'h3E);
      apb(1'b1, `LPCC_OFF_LPMC, 32'h00);
      $display("test sleep done");
      for (int w = 0; w < 4; w++)
      begin
         apb(1'b1, `LPCC_OFF_CKSC, 32'h04 | (w << 4));
         apb(1'b1, `LPCC_OFF_LPMC, 32'h80);
         wm(`LPCC_MODE_STOP);
         chk(osc_en_o, 1'b0);
         wk();
         chk(n >= wt[w] - 2 && n <= wt[w] + 4, 1'b1);
      end
      $display("test stop done");
      apb(1'b1, `LPCC_OFF_CKSC, 32'h31);
      wpl();
      hw_standby_i <= 1'b1;
      wm(`LPCC_MODE_HW_STANDBY);
      repeat (2) @(posedge clk_sys_i);
      chk({osc_en_o, sel_pll_o}, 2'b00);
      hw_standby_i <= 1'b0;
      @(posedge clk_sys_i);
      wk();
      chk({sel_pll_o, mode_o}, {1'b0, 3'h3});
      apb(1'b1, `LPCC_OFF_CKSC, 32'h32);
      wpl();
      watchdog_rst_i <= 1'b1;
      clk_sync_i <= 1'b1;
      @(posedge clk_sys_i);
      watchdog_rst_i <= 1'b0;
      wm(`LPCC_MODE_MAIN_RUN);
      clk_sync_i <= 1'b0;
      rd(`LPCC_OFF_CKSC, 33'hFE);
      $display("test standby done");
      for (int g = 0; g < 4; g++)
      begin
         apb(1'b1, `LPCC_OFF_LPMC, g << 1);
         cpu_access_i <= 1'b1;
         k = 0;
         n = 0;
         repeat (16)
         begin
            @(posedge clk_sys_i);
            k += (cpu_clk_en_o === 1'b0);
            n += (periph_clk_en_o !== 1'b1);
         end
         cpu_access_i <= 1'b0;
         chk(k, 16 - 16 / (g + 1));
         chk(n, 0);
      end
      $display("test intermittent done");
      clk_en_i <= 1'b0;
      apb(1'b1, `LPCC_OFF_CKSC, 32'h33);
      clk_en_i <= 1'b1;
      chk({pll_mult_o, sel_pll_o}, {2'b10, 1'b0});
      rd(`LPCC_OFF_CKSC, 33'hFE);
      $display("test clock enable done");
      test_done();
   end
endmodule
bind lpcc_top lpcc_assertions #(.PLL_LOCK_CYC(PLL_LOCK_CYC)) u_chk
(
   .clk_sys_i, .rst_n_i, .clk_en_i, .wake_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
   .hw_standby_i, .clk_sync_i, .osc_en_o, .pll_en_o, .pll_mult_o, .sel_pll_o,
   .cpu_clk_en_o, .periph_clk_en_o, .timebase_clk_en_o, .low_power_o, .mode_o
);
`default_nettype wire
